// >>> core/dtc_top.sv
// Purpose: sixteen-channel capture/compare unit on two reloadable time bases
// Assumes: AHB-Lite single word transfers, this slave alone on the bus
// Notes:   zero wait states; read data are taken in the address phase
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`include "dtc_cfg.svh"

// Notes on behaviour
// - sixteen channels, staggered mode slows to eight
// - two 16-bit time bases with reload
// - clock from prescaler taps or neighbour overflow
// - optional external count input drives time base
// - each channel picks time base and function
// - one pin per channel, input or output
// - capture latches assigned time base value
// - every capture raises channel interrupt
// - capture on rising, falling or both edges
// - compare channels checked on every count
// - mode 0 interrupts only, pin untouched
// - mode 1 toggles pin on every match
// - mode 2 one interrupt per period
// - mode 3 set on match, clear on overflow
// - paired channels toggle one shared pin
// - one-shot option stops after first event
module dtc_top (
   // clock and reset
   input  logic                clk,
   input  logic                arst_n,
   // ahb-lite slave
   input  logic                hsel,
   input  logic [31:0]         haddr,
   input  logic [1:0]          htrans,
   input  logic                hwrite,
   input  logic [2:0]          hsize,
   input  logic [31:0]         hwdata,
   input  logic                hready,
   output logic                hreadyout,
   output logic                hresp,
   output logic [31:0]         hrdata,
   // channel pins
   input  logic [`DTC_NCH-1:0] ch_pin_level,
   output logic [`DTC_NCH-1:0] ch_pin_drive,
   output logic [`DTC_NCH-1:0] ch_pin_en,
   // count sources
   input  logic                ext_count_pin,
   input  logic                neighbour_timer_overflow_source,
   // interrupt
   output logic                irq
);
   import dtc_pkg::*;

   localparam int NCH  = `DTC_NCH;
   localparam int HALF = `DTC_NCH / 2;

   dtc_top_st_t               q;
   dtc_top_st_t               d;
   logic [1:0]                rs_q;
   logic                      rst_s_n;
   dtc_tb_t [1:0]             tb;
   logic [1:0][15:0]          rld;
   logic [1:0]                tick;
   logic [1:0]                tb_wr_cnt;
   logic [1:0]                tb_wr_rld;
   logic [NCH-1:0][15:0]      ch_val;
   logic [NCH-1:0]            ch_hit;
   logic [NCH-1:0]            ch_irq;
   logic [NCH-1:0]            pair_hit;
   logic [NCH-1:0]            ch_wr_cfg;
   logic [NCH-1:0]            ch_wr_val;
   logic [`DTC_NIRQ-1:0]      stat_set;
   logic [`DTC_NIRQ-1:0]      stat_clr;
   logic [7:0]                div_mask;
   logic                      src_ev;
   logic                      ext_rise;
   logic                      take;
   logic                      wr;
   logic [7:0]                wa;
   logic [7:0]                ra;
   logic [31:0]               rd;

   // =========
   // reset release
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rs_q <= 2'h0;
      else
         rs_q <= {rs_q[0], 1'h1};
   end
   assign rst_s_n = rs_q[1];

   // =========
   // bus decode
   assign take = hsel & hready & htrans[1];
   assign wr = q.a_wr;
   assign wa = q.a_addr;
   assign ra = haddr[7:0];
   assign ext_rise = q.ext2 & ~q.ext_prev;
   assign stat_set = {tb[1].ovf, tb[0].ovf, ch_irq};
   assign stat_clr = (wr && wa == `DTC_A_STAT) ? hwdata[`DTC_NIRQ-1:0] : '0;

   always_comb
   begin
      for (int k = 0; k < 2; k++)
      begin
         tb_wr_cnt[k] = wr && wa < `DTC_A_GLOBAL && wa[4] == k[0]
                        && wa[3:0] == `DTC_O_TB_CNT;
         tb_wr_rld[k] = wr && wa < `DTC_A_GLOBAL && wa[4] == k[0]
                        && wa[3:0] == `DTC_O_TB_RLD;
      end
      for (int i = 0; i < NCH; i++)
      begin
         ch_wr_cfg[i] = wr && (wa & `DTC_CH_SEL) == `DTC_A_CH_CFG && wa[5:2] == i[3:0];
         ch_wr_val[i] = wr && (wa & `DTC_CH_SEL) == `DTC_A_CH_VAL && wa[5:2] == i[3:0];
      end
   end

   // =========
   // count enables
   always_comb
   begin
      div_mask = 8'h00;
      src_ev = 1'h0;
      for (int k = 0; k < 2; k++)
      begin
         // prescaler tap: divide by two to the power div
         div_mask = 8'((8'h01 << q.tbc[k].div) - 8'h01);
         unique case (q.tbc[k].src)
            DTC_SRC_PRE: src_ev = (q.pre & div_mask) == 8'h00;
            DTC_SRC_NB:  src_ev = neighbour_timer_overflow_source;
            DTC_SRC_EXT: src_ev = ext_rise;
            default:     src_ev = 1'h0;
         endcase
         // staggered mode lets a count through only once in eight cycles
         tick[k] = q.tbc[k].run & src_ev & (~q.staggered | q.stag == 3'h0);
      end
   end

   // =========
   // read mux, evaluated in the address phase
   always_comb
   begin
      rd = 32'h0000_0000;
      if (ra < `DTC_A_GLOBAL)
      begin
         unique case (ra[3:0])
            `DTC_O_TB_CTRL: rd[`DTC_TBC_W-1:0] = q.tbc[ra[4]];
            `DTC_O_TB_CNT:  rd[15:0] = tb[ra[4]].cnt;
            `DTC_O_TB_RLD:  rd[15:0] = rld[ra[4]];
            default:        rd = 32'h0000_0000;
         endcase
      end
      else if ((ra & `DTC_CH_SEL) == `DTC_A_CH_CFG)
         rd[`DTC_CHC_W-1:0] = q.chc[ra[5:2]];
      else if ((ra & `DTC_CH_SEL) == `DTC_A_CH_VAL)
         rd[15:0] = ch_val[ra[5:2]];
      else
      begin
         unique case (ra)
            `DTC_A_GLOBAL: rd[`DTC_GLB_STAG] = q.staggered;
            `DTC_A_STAT:   rd[`DTC_NIRQ-1:0] = q.stat;
            `DTC_A_MASK:   rd[`DTC_NIRQ-1:0] = q.mask;
            `DTC_A_PINS:   rd = {q.sync2, ch_pin_drive};
            default:       rd = 32'h0000_0000;
         endcase
      end
   end

   // =========
   // next state
   always_comb
   begin
      d = q;
      d.sync1 = ch_pin_level;
      d.sync2 = q.sync1;
      d.ext1 = ext_count_pin;
      d.ext2 = q.ext1;
      d.ext_prev = q.ext2;
      d.pre = q.pre + 8'h01;
      d.stag = (q.stag == `DTC_STAG_LAST) ? 3'h0 : q.stag + 3'h1;
      // a new event wins over a clear in the same cycle
      d.stat = (q.stat & ~stat_clr) | stat_set;
      d.a_wr = take & hwrite;
      d.a_rd = take & ~hwrite;
      d.a_addr = haddr[7:0];
      if (take && !hwrite)
         d.rdata = rd;
      if (wr)
      begin
         if (wa < `DTC_A_GLOBAL && wa[3:0] == `DTC_O_TB_CTRL)
            d.tbc[wa[4]] = dtc_tbcfg_t'(hwdata[`DTC_TBC_W-1:0]);
         if ((wa & `DTC_CH_SEL) == `DTC_A_CH_CFG)
            d.chc[wa[5:2]] = dtc_chcfg_t'(hwdata[`DTC_CHC_W-1:0]);
         if (wa == `DTC_A_GLOBAL)
            d.staggered = hwdata[`DTC_GLB_STAG];
         if (wa == `DTC_A_MASK)
            d.mask = hwdata[`DTC_NIRQ-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         q <= '0;
         q.tbc <= {`DTC_RST_TBC, `DTC_RST_TBC};
         q.mask <= `DTC_RST_MASK;
      end
      else
         q <= d;
   end

   // =========
   // time bases
   dtc_timebase u_first_time_base (
      .clk    (clk),
      .rst_n  (rst_s_n),
      .tick   (tick[0]),
      .wr_cnt (tb_wr_cnt[0]),
      .wr_rld (tb_wr_rld[0]),
      .wdata  (hwdata[15:0]),
      .tb     (tb[0]),
      .rld    (rld[0])
   );

   dtc_timebase u_second_time_base (
      .clk    (clk),
      .rst_n  (rst_s_n),
      .tick   (tick[1]),
      .wr_cnt (tb_wr_cnt[1]),
      .wr_rld (tb_wr_rld[1]),
      .wdata  (hwdata[15:0]),
      .tb     (tb[1]),
      .rld    (rld[1])
   );

   // =========
   // channels
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      // the low half may borrow the match of its partner in the high half
      if (i < HALF)
      begin : g_pair
         assign pair_hit[i] = ch_hit[i + HALF];
      end
      else
      begin : g_solo
         assign pair_hit[i] = 1'h0;
      end
      dtc_chan u_chan (
         .clk      (clk),
         .rst_n    (rst_s_n),
         .cfg      (q.chc[i]),
         .wr_cfg   (ch_wr_cfg[i]),
         .wr_val   (ch_wr_val[i]),
         .wdata    (hwdata[15:0]),
         .tb0      (tb[0]),
         .tb1      (tb[1]),
         .pin_s    (q.sync2[i]),
         .pair_hit (pair_hit[i]),
         .val      (ch_val[i]),
         .pin_out  (ch_pin_drive[i]),
         .pin_en   (ch_pin_en[i]),
         .hit      (ch_hit[i]),
         .irq      (ch_irq[i])
      );
   end

   // =========
   // outputs
   assign hreadyout = 1'h1;
   assign hresp = 1'h0;
   assign hrdata = q.rdata;
   assign irq = |(q.stat & q.mask);

   // =========
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_s_n);
   chk_irq_follows_event: assert property (|(ch_irq & q.mask[NCH-1:0])
      && !(wr && wa == `DTC_A_MASK) |=> irq)
      else $error("unmasked channel event did not raise irq");
   chk_stagger_slot: assert property (q.staggered && |tick |-> q.stag == 3'h0)
      else $error("count outside the staggered slot");
   chk_sync_two_flops: assert property ($changed(q.sync2) |-> q.sync2 == $past(q.sync1))
      else $error("pin reached logic without two flops");
   chk_neighbour_tick: assert property (q.tbc[1].run && q.tbc[1].src == DTC_SRC_NB
      && !q.staggered && neighbour_timer_overflow_source && !tb_wr_cnt[1]
      |-> tick[1] ##1 tb[1].step)
      else $error("neighbour overflow did not count");
   chk_ext_count: assert property (q.tbc[1].run && q.tbc[1].src == DTC_SRC_EXT
      && !q.staggered && ext_rise && !tb_wr_cnt[1] |=> tb[1].step)
      else $error("external count edge lost");
endmodule // dtc_top

// >>> core/dtc_cfg.svh
// Purpose: constants of the dual time base capture/compare unit
// Assumes: included by dtc_pkg, dtc_top, dtc_timebase and the bench
// Notes:   byte offsets on a 32-bit word bus
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
// =========
// sizes
`define DTC_NCH        16
`define DTC_NIRQ       18
`define DTC_TBC_W      6
`define DTC_CHC_W      7
// =========
// register offsets
`define DTC_O_TB_CTRL  4'h0
`define DTC_O_TB_CNT   4'h4
`define DTC_O_TB_RLD   4'h8
`define DTC_A_GLOBAL   8'h20
`define DTC_A_STAT     8'h24
`define DTC_A_MASK     8'h28
`define DTC_A_PINS     8'h2c
`define DTC_A_CH_CFG   8'h40
`define DTC_A_CH_VAL   8'h80
`define DTC_CH_SEL     8'hc0
// =========
// fields and reset values
`define DTC_GLB_STAG   0
`define DTC_RST_TBC    6'h00
`define DTC_RST_RLD    16'h0000
`define DTC_RST_MASK   18'h00000
// =========
// timing
`define DTC_TB_TOP     16'hffff
`define DTC_STAG_LAST  3'h7
`endif

// >>> core/dtc_pkg.sv
// Purpose: types of the dual time base capture/compare unit
// Assumes: dtc_cfg.svh on the include path
// Notes:   field layout of control registers is given by the structs
`include "dtc_cfg.svh"
package dtc_pkg;
   typedef enum logic [3:0] {
      DTC_OFF      = 4'h0,
      DTC_CAP_RISE = 4'h1,
      DTC_CAP_FALL = 4'h2,
      DTC_CAP_BOTH = 4'h3,
      DTC_CMP0     = 4'h4,
      DTC_CMP1     = 4'h5,
      DTC_CMP2     = 4'h6,
      DTC_CMP3     = 4'h7
   } dtc_mode_t;
   typedef enum logic [1:0] {
      DTC_SRC_PRE = 2'h0,
      DTC_SRC_NB  = 2'h1,
      DTC_SRC_EXT = 2'h2,
      DTC_SRC_RSV = 2'h3
   } dtc_src_t;
   typedef struct packed {
      logic     run;
      dtc_src_t src;
      logic [2:0] div;
   } dtc_tbcfg_t;
   typedef struct packed {
      logic      one_shot;
      logic      paired;
      logic      tb_sel;
      dtc_mode_t mode;
   } dtc_chcfg_t;
   typedef struct packed {
      logic [15:0] cnt;
      logic        step;
      logic        ovf;
   } dtc_tb_t;
   typedef struct packed {
      dtc_tb_t     tb;
      logic [15:0] rld;
   } dtc_tb_st_t;
   typedef struct packed {
      logic [15:0] val;
      logic        pin;
      logic        in_prev;
      logic        fired;
      logic        done;
   } dtc_ch_st_t;
   typedef struct packed {
      logic [`DTC_NCH-1:0]        sync1;
      logic [`DTC_NCH-1:0]        sync2;
      logic                       ext1;
      logic                       ext2;
      logic                       ext_prev;
      logic [7:0]                 pre;
      logic [2:0]                 stag;
      logic                       staggered;
      dtc_tbcfg_t [1:0]           tbc;
      dtc_chcfg_t [`DTC_NCH-1:0]  chc;
      logic [`DTC_NIRQ-1:0]       stat;
      logic [`DTC_NIRQ-1:0]       mask;
      logic                       a_wr;
      logic                       a_rd;
      logic [7:0]                 a_addr;
      logic [31:0]                rdata;
   } dtc_top_st_t;
endpackage

// >>> core/dtc_timebase.sv
// Purpose: one 16-bit reloadable time base
// Assumes: tick is a one-cycle enable from the same clock
// Notes:   step marks the cycle in which cnt holds a fresh count
`include "dtc_cfg.svh"
module dtc_timebase (
   // clock and reset
   input  logic             clk,
   input  logic             rst_n,
   // count enable and software access
   input  logic             tick,
   input  logic             wr_cnt,
   input  logic             wr_rld,
   input  logic [15:0]      wdata,
   // state
   output dtc_pkg::dtc_tb_t tb,
   output logic [15:0]      rld
);
   import dtc_pkg::*;
   dtc_tb_st_t q;
   dtc_tb_st_t d;

   always_comb
   begin
      d = q;
      d.tb.step = 1'h0;
      d.tb.ovf = 1'h0;
      if (wr_rld)
         d.rld = wdata;
      // a software write of the count beats a pending tick
      if (wr_cnt)
         d.tb.cnt = wdata;
      else if (tick)
      begin
         d.tb.step = 1'h1;
         if (q.tb.cnt == `DTC_TB_TOP)
         begin
            d.tb.cnt = q.rld;
            d.tb.ovf = 1'h1;
         end
         else
            d.tb.cnt = q.tb.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.rld <= `DTC_RST_RLD;
      end
      else
         q <= d;
   end

   assign tb = q.tb;
   assign rld = q.rld;

   // =========
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_tb_reload_load: assert property (tick && !wr_cnt && q.tb.cnt == `DTC_TB_TOP
      |=> q.tb.cnt == $past(q.rld) && q.tb.ovf && q.tb.step)
      else $error("time base not reloaded at overflow");
   chk_tb_count_step: assert property (tick && !wr_cnt && q.tb.cnt != `DTC_TB_TOP
      |=> q.tb.cnt == $past(q.tb.cnt) + 16'h0001 && !q.tb.ovf)
      else $error("time base did not advance by one");
endmodule // dtc_timebase

// >>> core/dtc_chan.sv
// Purpose: one capture/compare channel with its pin
// Assumes: pin_s already synchronised to clk
// Notes:   capture wins over a same-cycle software write of the value
module dtc_chan (
   // clock and reset
   input  logic                clk,
   input  logic                rst_n,
   // configuration and software access
   input  dtc_pkg::dtc_chcfg_t cfg,
   input  logic                wr_cfg,
   input  logic                wr_val,
   input  logic [15:0]         wdata,
   // time bases
   input  dtc_pkg::dtc_tb_t    tb0,
   input  dtc_pkg::dtc_tb_t    tb1,
   // pin and pairing
   input  logic                pin_s,
   input  logic                pair_hit,
   output logic [15:0]         val,
   output logic                pin_out,
   output logic                pin_en,
   output logic                hit,
   output logic                irq
);
   import dtc_pkg::*;
   dtc_ch_st_t q;
   dtc_ch_st_t d;
   dtc_tb_t    tb;
   logic       cap_ev;
   logic       is_cmp;
   logic       blocked;
   logic       fired_now;

   always_comb
   begin
      tb = cfg.tb_sel ? tb1 : tb0;
      blocked = cfg.one_shot & q.done;
      cap_ev = 1'h0;
      is_cmp = 1'h0;
      unique case (cfg.mode)
         DTC_CAP_RISE: cap_ev = pin_s & ~q.in_prev;
         DTC_CAP_FALL: cap_ev = ~pin_s & q.in_prev;
         DTC_CAP_BOTH: cap_ev = pin_s ^ q.in_prev;
         DTC_CMP0, DTC_CMP1, DTC_CMP2, DTC_CMP3: is_cmp = 1'h1;
         default: is_cmp = 1'h0;
      endcase
      cap_ev = cap_ev & ~blocked;
      hit = is_cmp & tb.step & (tb.cnt == q.val) & ~blocked;
      // a new period re-arms the once-per-period modes first
      fired_now = q.fired & ~tb.ovf;
      d = q;
      d.in_prev = pin_s;
      irq = 1'h0;
      if (tb.ovf)
         d.fired = 1'h0;
      if (cfg.mode == DTC_CMP3 && tb.ovf)
         d.pin = 1'h0;
      if (cap_ev)
      begin
         d.val = tb.cnt;
         irq = 1'h1;
         d.done = cfg.one_shot;
      end
      else if (wr_val)
         d.val = wdata;
      if (hit)
      begin
         d.done = cfg.one_shot;
         unique case (cfg.mode)
            DTC_CMP0: irq = 1'h1;
            DTC_CMP1:
            begin
               irq = 1'h1;
               d.pin = ~q.pin;
            end
            DTC_CMP2:
            begin
               irq = ~fired_now;
               d.fired = 1'h1;
            end
            DTC_CMP3:
            begin
               irq = ~fired_now;
               d.pin = q.pin | ~fired_now;
               d.fired = 1'h1;
            end
            default: irq = 1'h0;
         endcase
      end
      if (cfg.paired && pair_hit)
         d.pin = ~d.pin;
      if (wr_cfg)
      begin
         d.done = 1'h0;
         d.fired = 1'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign val = q.val;
   assign pin_out = q.pin;
   assign pin_en = (cfg.mode == DTC_CMP1) | (cfg.mode == DTC_CMP3) | cfg.paired;

   // =========
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_capture;
      cap_ev && irq;
   endsequence
   sequence s_m3_ovf;
      cfg.mode == DTC_CMP3 && tb.ovf && !hit && !(cfg.paired && pair_hit);
   endsequence
   chk_capture_latch: assert property (s_capture |=> q.val == $past(tb.cnt))
      else $error("capture did not latch the time base");
   chk_mode2_once: assert property (cfg.mode == DTC_CMP2 && q.fired && !tb.ovf |-> !irq)
      else $error("second mode 2 interrupt in one period");
   chk_mode1_toggle: assert property (hit && cfg.mode == DTC_CMP1 && !(cfg.paired && pair_hit)
      |=> q.pin != $past(q.pin))
      else $error("mode 1 match did not toggle the pin");
   chk_mode3_clear: assert property (s_m3_ovf |=> !q.pin)
      else $error("mode 3 pin not cleared at overflow");
   chk_mode0_pin: assert property (cfg.mode == DTC_CMP0 && !cfg.paired && !wr_cfg
      |=> q.pin == $past(q.pin))
      else $error("mode 0 changed the pin");
   chk_one_shot_hold: assert property (cfg.one_shot && q.done && !wr_cfg
      |-> !irq ##1 !irq)
      else $error("one shot channel fired again");
endmodule // dtc_chan

// >>> verification/dtc_pin_model.sv
// Purpose: far side of the channel port pins
// Assumes: bench sets the outside level of every pin
// Notes:   a pin the unit drives reads back the unit's level
module dtc_pin_model (
   // unit side
   input  wire logic [15:0] drive,
   input  wire logic [15:0] en,
   // outside source
   input  wire logic [15:0] ext_lvl,
   output logic [15:0]      level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // wire level: the unit wins where it drives, no contention modelled
   assign level = (drive & en) | (ext_lvl & ~en);
endmodule // dtc_pin_model

// >>> verification/test_dual_timebase_capture_compare.sv
// Purpose: self-checking bench of the capture/compare unit
// Assumes: zero wait state slave, prescaler div 0 ticks every cycle
// Notes:   short periods via reload 0xfff0 keep the run brief
`include "dtc_cfg.svh"
`define CHK(g,e) begin checks_done++; if ((g)!==(e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_dual_timebase_capture_compare;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0;
   logic        arst_n = 0;
   logic        hsel = 0;
   logic        hwrite = 0;
   logic        nb = 0;
   logic        ext = 0;
   logic [31:0] haddr = 0;
   logic [31:0] hwdata = 0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic [15:0] lvl;
   logic [15:0] drv;
   logic [15:0] en;
   logic [15:0] xl = 0;
   int          n_fail = 0;
   int          checks_done = 0;
   int          t;
   always #4 clk = ~clk;
   dtc_top dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ch_pin_level(lvl),
      .ch_pin_drive(drv), .ch_pin_en(en), .ext_count_pin(ext),
      .neighbour_timer_overflow_source(nb), .irq(irq));
   dtc_pin_model pins (.drive(drv), .en(en), .ext_lvl(xl), .level(lvl));
   // ==========
   // closing report
   task automatic give_verdict(input bit hung);
      if (hung)
         n_fail++;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========
   // bus and wait helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100)
         give_verdict(1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // cycles until pin i shows v; a hang ends the run
   task automatic wait_drv(input int i, input logic v);
      t = 0;
      do begin @(posedge clk); t++; end while (drv[i] !== v && t < 60);
      if (t >= 60)
         give_verdict(1);
   endtask
   // ==========
   // scenarios
   task automatic t_reset;
      `CHK({hreadyout, hresp, irq, en}, 19'h40000)
      rdc(8'h00, 32'h0);
      rdc(`DTC_A_MASK, 32'h0);
      rdc(8'h3c, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_sources;
      wr(8'h14, 32'h0);
      wr(8'h10, 32'h28);
      repeat (5)
      begin
         nb <= 1'b1;
         cyc(1);
         nb <= 1'b0;
         cyc(2);
      end
      rdc(8'h14, 32'h5);
      wr(8'h10, 32'h30);
      wr(8'h14, 32'h0);
      repeat (3)
      begin
         ext <= 1'b1;
         cyc(3);
         ext <= 1'b0;
         cyc(3);
      end
      rdc(8'h14, 32'h3);
      wr(`DTC_A_GLOBAL, 32'h1);
      wr(8'h10, 32'h20);
      cyc(80);
      wr(8'h10, 32'h0);
      bus(1'b0, 8'h14, 32'h0);
      // three counts remain from the edge test; 82 run cycles give 10 or 11 slots
      `CHK(rd inside {[13:14]}, 1'b1)
      wr(`DTC_A_GLOBAL, 32'h0);
      $display("t_sources done");
   endtask
   task automatic t_toggle;
      wr(8'h08, 32'hfff0);
      wr(8'h04, 32'hfff0);
      wr(8'h84, 32'hfff4);
      wr(8'h44, 32'h05);
      cyc(1);
      `CHK(en[1], 1'b1)
      wr(8'h00, 32'h20);
      wait_drv(1, 1'b1);
      wait_drv(1, 1'b0);
      `CHK(t, 16)
      wr(8'h44, 32'h45);
      wait_drv(1, 1'b1);
      // one period later a repeating channel would have toggled once
      cyc(20);
      `CHK(drv[1], 1'b1)
      wr(8'h44, 32'h0);
      $display("t_toggle done");
   endtask
   task automatic t_mode3;
      wr(8'h88, 32'hfff8);
      wr(8'h48, 32'h07);
      wait_drv(2, 1'b1);
      wait_drv(2, 1'b0);
      `CHK(t, 8)
      wr(8'h48, 32'h0);
      $display("t_mode3 done");
   endtask
   task automatic t_mode0;
      wr(`DTC_A_MASK, 32'h8);
      wr(8'h8c, 32'hfff2);
      wr(8'h4c, 32'h04);
      wr(`DTC_A_STAT, 32'h3ffff);
      cyc(20);
      rdc(`DTC_A_STAT, 32'h10008);
      `CHK({irq, en[3], drv[3]}, 3'h4)
      wr(`DTC_A_MASK, 32'h0);
      cyc(1);
      `CHK(irq, 1'b0)
      wr(`DTC_A_MASK, 32'h10000);
      cyc(1);
      `CHK(irq, 1'b1)
      wr(8'h00, 32'h0);
      wr(8'h4c, 32'h0);
      wr(`DTC_A_STAT, 32'h3ffff);
      cyc(1);
      `CHK(irq, 1'b0)
      $display("t_mode0 done");
   endtask
   // both edges per trigger mode, time base 1 held at a known count
   task automatic t_capture;
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h1234);
      wr(`DTC_A_MASK, 32'h10);
      for (int m = 1; m <= 3; m++)
      begin
         wr(8'h90, 32'h0);
         wr(8'h50, 32'h10 | m);
         wr(`DTC_A_STAT, 32'h3ffff);
         xl[4] <= 1'b1;
         cyc(6);
         rdc(`DTC_A_STAT, (m != 2) ? 32'h10 : 32'h0);
         wr(`DTC_A_STAT, 32'h3ffff);
         xl[4] <= 1'b0;
         cyc(6);
         rdc(`DTC_A_STAT, (m != 1) ? 32'h10 : 32'h0);
         rdc(8'h90, 32'h1234);
         `CHK(en[4], 1'b0)
      end
      $display("t_capture done");
   endtask
   // mode 2 once per period, then a paired pin toggled by both matches
   task automatic t_mode2_pair;
      wr(8'h94, 32'hfff4);
      wr(8'h54, 32'h06);
      wr(8'h04, 32'hfff0);
      wr(`DTC_A_STAT, 32'h3ffff);
      wr(8'h00, 32'h20);
      cyc(6);
      rdc(`DTC_A_STAT, 32'h20);
      wr(`DTC_A_STAT, 32'h3ffff);
      // rewind inside the period: the second match must stay silent
      wr(8'h04, 32'hfff0);
      cyc(6);
      rdc(`DTC_A_STAT, 32'h0);
      wr(8'ha0, 32'hfff8);
      wr(8'h60, 32'h04);
      wr(8'h80, 32'hfff2);
      wr(8'h40, 32'h25);
      wait_drv(0, 1'b1);
      wait_drv(0, 1'b0);
      // gaps of 6 or 10 counts; one register alone would give 16
      `CHK((t == 6) || (t == 10), 1'b1)
      `CHK({en[0], en[8], drv[8]}, 3'h4)
      $display("t_mode2_pair done");
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      cyc(3);
      t_reset();
      t_sources();
      t_toggle();
      t_mode3();
      t_mode0();
      t_capture();
      t_mode2_pair();
      give_verdict(0);
   end
endmodule // test_dual_timebase_capture_compare
